// ==== logic/psc_map.svh ====
// Offsets, field positions, reset values and timing counts of the sideband control block.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define PSC_CLK_PERIOD_NS 20
`define PSC_DEBOUNCE_NS 150
`define PSC_DEBOUNCE_CYC ((`PSC_DEBOUNCE_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`define PSC_OSC_VALID_US 30
`define PSC_OSC_VALID_CYC ((`PSC_OSC_VALID_US * 1000 + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Positions in the synchronised input vector
// ---------------------------------------------------------------
`define PSC_SYNC_WIDTH 14
`define PSC_POS_VCODE 0
`define PSC_POS_RSEL0 7
`define PSC_POS_RSEL1 8
`define PSC_POS_STBY 9
`define PSC_POS_THERM_N 10
`define PSC_POS_RAILS_OK 11
`define PSC_POS_OSC_OK 12
`define PSC_POS_XTAL 13

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PSC_SYNC_RST 14'h0400
`define PSC_STANDBY_RST 1'b1

`endif

// ==== logic/psc_pkg.sv ====
// Types shared by the sideband control block.
package psc_pkg;
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_WAIT_OSC,
    PWR_GOOD
  } psc_pwr_state_type;
endpackage

// ==== logic/psc_sideband.sv ====
// Sideband control between the power manager, the controller hub and the CPU.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"

// Notes on behaviour
// - Wake interrupt is a level held until the hub's clearing read.
// - Regulation-done flag rises once a voltage request is decoded.
// - Regulation-done flag falls when the affected rail reaches regulation.
// - Active-low hub hard reset output; hub returns to default while low.
// - Rails-good only while every hub rail is good.
// - Rails-good waits until oscillator supply valid at least 30 us.
// - Standby exit leaves always-on standby and switches configured regulators on.
// - Two rail-select inputs choose core or second rail; debounced 150 ns.
// - Seven-bit voltage code sets selected rail voltage; debounced 150 ns.
// - Crystal oscillator at 32.768 kHz gives a free-running slow clock output.
module psc_sideband
  import psc_pkg::*;
#(
  parameter int DEB_CYC = `PSC_DEBOUNCE_CYC,
  parameter int OSC_CYC = `PSC_OSC_VALID_CYC
)(
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic WAKE_EVENT_I,
  input wire logic HUB_READ_CLEAR_I,
  output logic HOST_WAKE_INTERRUPT_O,
  input wire logic SERIAL_VREQ_I,
  input wire logic RAIL_REGULATED_I,
  output logic REGULATION_DONE_FLAG_O,
  output logic VREQ_VALID_O,
  output logic [1:0] VREQ_RAIL_SELECT_O,
  output logic [6:0] VREQ_VOLTAGE_CODE_O,
  input wire logic HUB_RESET_REQ_I,
  output logic HUB_HARD_RESET_N_O,
  input wire logic HUB_RAILS_OK_I,
  input wire logic OSCILLATOR_SUPPLY_I,
  output logic RAILS_GOOD_O,
  input wire logic STANDBY_EXIT_REQUEST_I,
  input wire logic STANDBY_ENTER_I,
  output logic ALWAYS_ON_STANDBY_O,
  output logic REGULATOR_SWITCH_ON_O,
  input wire logic THERMAL_TRIP_N_I,
  output logic THERMAL_TRIP_O,
  input wire logic [1:0] RAIL_SELECT_I,
  input wire logic [6:0] VOLTAGE_CODE_I,
  input wire logic CRYSTAL_IN_I,
  output logic CRYSTAL_OUT_O,
  output logic SLOW_CLOCK_OUT_O
);

  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int OW = $clog2(OSC_CYC + 1);
  localparam logic [DW-1:0] DEB_LIM = DW'(DEB_CYC);
  localparam logic [OW-1:0] OSC_LIM = OW'(OSC_CYC);
  localparam logic [`PSC_SYNC_WIDTH-1:0] SYNC_RST = `PSC_SYNC_RST;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [`PSC_SYNC_WIDTH-1:0] pins;
  logic [`PSC_SYNC_WIDTH-1:0] s1_q;
  logic [`PSC_SYNC_WIDTH-1:0] s2_q;
  logic [`PSC_SYNC_WIDTH-1:0] s3_q;
  logic [`PSC_SYNC_WIDTH-1:0] filt_q;
  logic [`PSC_SYNC_WIDTH-1:0] filt_d;

  assign pins = {CRYSTAL_IN_I, OSCILLATOR_SUPPLY_I, HUB_RAILS_OK_I, THERMAL_TRIP_N_I,
                 STANDBY_EXIT_REQUEST_I, RAIL_SELECT_I, VOLTAGE_CODE_I};

  genvar g;
  generate
    for (g = 0; g < `PSC_SYNC_WIDTH; g++)
    begin : g_sync
      // A change is accepted only once the second and third stages agree.
      always_comb
      begin
        filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
      end

      always_ff @(posedge CORE_CLK_I or negedge NRST_I)
      begin
        if (!NRST_I)
        begin
          s1_q[g] <= SYNC_RST[g];
          s2_q[g] <= SYNC_RST[g];
          s3_q[g] <= SYNC_RST[g];
          filt_q[g] <= SYNC_RST[g];
        end
        else
        begin
          s1_q[g] <= pins[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          filt_q[g] <= filt_d[g];
        end
      end
    end
  endgenerate

  logic [8:0] vid_f;
  assign vid_f = filt_q[`PSC_POS_RSEL1:`PSC_POS_VCODE];

  // ---------------------------------------------------------------
  // Voltage request debounce and regulation handshake
  // ---------------------------------------------------------------
  logic [8:0] vid_last_q;
  logic [8:0] vid_last_d;
  logic [DW-1:0] deb_cnt_q;
  logic [DW-1:0] deb_cnt_d;
  logic vreq_q;
  logic vreq_d;
  logic [8:0] vreq_val_q;
  logic [8:0] vreq_val_d;
  logic vdone_q;
  logic vdone_d;

  always_comb
  begin
    vid_last_d = vid_f;
    deb_cnt_d = deb_cnt_q;
    vreq_d = 1'b0;
    vreq_val_d = vreq_val_q;
    if (vid_f != vid_last_q)
    begin
      deb_cnt_d = '0;
    end
    else if (deb_cnt_q != DEB_LIM)
    begin
      deb_cnt_d = deb_cnt_q + 1'b1;
      if (deb_cnt_q == DEB_LIM - 1'b1)
      begin
        // Whole window stable: take the request once.
        vreq_d = 1'b1;
        vreq_val_d = vid_f;
      end
    end
    vdone_d = vdone_q;
    if (RAIL_REGULATED_I)
    begin
      vdone_d = 1'b0;
    end
    if (SERIAL_VREQ_I || vreq_q)
    begin
      vdone_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      vid_last_q <= 9'h000;
      deb_cnt_q <= '0;
      vreq_q <= 1'b0;
      vreq_val_q <= 9'h000;
      vdone_q <= 1'b0;
    end
    else
    begin
      vid_last_q <= vid_last_d;
      deb_cnt_q <= deb_cnt_d;
      vreq_q <= vreq_d;
      vreq_val_q <= vreq_val_d;
      vdone_q <= vdone_d;
    end
  end

  assign VREQ_VALID_O = vreq_q;
  assign VREQ_RAIL_SELECT_O = vreq_val_q[8:7];
  assign VREQ_VOLTAGE_CODE_O = vreq_val_q[6:0];
  assign REGULATION_DONE_FLAG_O = vdone_q;

  // ---------------------------------------------------------------
  // Power good sequencing and hub reset
  // ---------------------------------------------------------------
  psc_pwr_state_type pwr_q;
  psc_pwr_state_type pwr_d;
  logic [OW-1:0] osc_cnt_q;
  logic [OW-1:0] osc_cnt_d;
  logic hub_rst_n_q;
  logic hub_rst_n_d;
  logic rails_ok;
  logic osc_ok;

  assign rails_ok = filt_q[`PSC_POS_RAILS_OK];
  assign osc_ok = filt_q[`PSC_POS_OSC_OK];

  always_comb
  begin
    pwr_d = pwr_q;
    osc_cnt_d = osc_cnt_q;
    if (!osc_ok)
    begin
      osc_cnt_d = '0;
    end
    else if (osc_cnt_q != OSC_LIM)
    begin
      osc_cnt_d = osc_cnt_q + 1'b1;
    end
    unique case (pwr_q)
      PWR_OFF:
      begin
        if (rails_ok)
        begin
          pwr_d = PWR_WAIT_OSC;
        end
      end
      PWR_WAIT_OSC:
      begin
        if (!rails_ok)
        begin
          pwr_d = PWR_OFF;
        end
        else if (osc_ok && osc_cnt_q == OSC_LIM)
        begin
          pwr_d = PWR_GOOD;
        end
      end
      PWR_GOOD:
      begin
        if (!rails_ok || !osc_ok)
        begin
          pwr_d = PWR_OFF;
        end
      end
      default:
      begin
        pwr_d = PWR_OFF;
      end
    endcase
    // The hub is held in reset until power is good, keeping it off.
    hub_rst_n_d = (pwr_q == PWR_GOOD) && !HUB_RESET_REQ_I;
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pwr_q <= PWR_OFF;
      osc_cnt_q <= '0;
      hub_rst_n_q <= 1'b0;
    end
    else
    begin
      pwr_q <= pwr_d;
      osc_cnt_q <= osc_cnt_d;
      hub_rst_n_q <= hub_rst_n_d;
    end
  end

  assign RAILS_GOOD_O = (pwr_q == PWR_GOOD);
  assign HUB_HARD_RESET_N_O = hub_rst_n_q;

  // ---------------------------------------------------------------
  // Wake interrupt, standby exit, thermal trip and slow clock
  // ---------------------------------------------------------------
  logic wake_q;
  logic wake_d;
  logic stby_q;
  logic stby_d;
  logic exit_prev_q;
  logic exit_prev_d;
  logic sw_on_q;
  logic sw_on_d;
  logic therm_q;
  logic therm_d;
  logic slow_q;
  logic slow_d;
  logic exit_f;

  assign exit_f = filt_q[`PSC_POS_STBY];

  always_comb
  begin
    wake_d = wake_q;
    if (HUB_READ_CLEAR_I)
    begin
      wake_d = 1'b0;
    end
    if (WAKE_EVENT_I)
    begin
      wake_d = 1'b1;
    end
    exit_prev_d = exit_f;
    sw_on_d = exit_f && !exit_prev_q;
    stby_d = stby_q;
    if (STANDBY_ENTER_I)
    begin
      stby_d = 1'b1;
    end
    if (exit_f && !exit_prev_q)
    begin
      stby_d = 1'b0;
    end
    therm_d = !filt_q[`PSC_POS_THERM_N];
    slow_d = filt_q[`PSC_POS_XTAL];
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wake_q <= 1'b0;
      stby_q <= `PSC_STANDBY_RST;
      exit_prev_q <= 1'b0;
      sw_on_q <= 1'b0;
      therm_q <= 1'b0;
      slow_q <= 1'b0;
    end
    else
    begin
      wake_q <= wake_d;
      stby_q <= stby_d;
      exit_prev_q <= exit_prev_d;
      sw_on_q <= sw_on_d;
      therm_q <= therm_d;
      slow_q <= slow_d;
    end
  end

  assign HOST_WAKE_INTERRUPT_O = wake_q;
  assign ALWAYS_ON_STANDBY_O = stby_q;
  assign REGULATOR_SWITCH_ON_O = sw_on_q;
  assign THERMAL_TRIP_O = therm_q;
  assign SLOW_CLOCK_OUT_O = slow_q;
  // Inverting amplifier that sustains the crystal.
  assign CRYSTAL_OUT_O = !CRYSTAL_IN_I;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_exit_edge;
    exit_f && !exit_prev_q;
  endsequence

  sequence s_switch_done;
    REGULATOR_SWITCH_ON_O && !ALWAYS_ON_STANDBY_O;
  endsequence

  a_wake_hold: assert property (HOST_WAKE_INTERRUPT_O && !HUB_READ_CLEAR_I
    |=> HOST_WAKE_INTERRUPT_O) else $error("wake level dropped without read");
  a_wake_set: assert property (WAKE_EVENT_I |=> HOST_WAKE_INTERRUPT_O)
    else $error("wake event lost");
  a_vdone_set: assert property ((SERIAL_VREQ_I || VREQ_VALID_O) |=> REGULATION_DONE_FLAG_O)
    else $error("regulation flag not raised");
  a_vdone_clear: assert property (RAIL_REGULATED_I && !SERIAL_VREQ_I && !VREQ_VALID_O
    |=> !REGULATION_DONE_FLAG_O) else $error("regulation flag not cleared");
  a_hub_reset_low: assert property (!RAILS_GOOD_O |-> ##1 !HUB_HARD_RESET_N_O)
    else $error("hub out of reset without power good");
  a_rails_all_good: assert property (RAILS_GOOD_O |-> $past(rails_ok))
    else $error("rails good without all rails");
  a_osc_wait: assert property ($rose(RAILS_GOOD_O) |-> $past(osc_cnt_q) == OSC_LIM)
    else $error("rails good before oscillator window");
  a_standby_exit: assert property (s_exit_edge |=> s_switch_done)
    else $error("standby exit not acted on");
  a_vid_window: assert property (VREQ_VALID_O |-> deb_cnt_q == DEB_LIM
    && vid_last_q == {VREQ_RAIL_SELECT_O, VREQ_VOLTAGE_CODE_O})
    else $error("voltage request before debounce window");
  a_thermal_sync: assert property ($fell(THERMAL_TRIP_N_I) ##1 !THERMAL_TRIP_N_I [*4]
    |=> THERMAL_TRIP_O) else $error("thermal trip not passed");

endmodule
`default_nettype wire

// ==== dv/psc_hub_model.sv ====
// Behavioural hub and CPU on the far side of the sideband block.
`timescale 1ns/1ps
`default_nettype none
module psc_hub_model (
  input wire logic clk,
  input wire logic rails_good,
  input wire logic hard_reset_n,
  input wire logic trip,
  input wire logic [8:0] vreq,
  output logic hub_on,
  output logic thermal_n,
  output logic [1:0] rsel,
  output logic [6:0] code
);
  // The hub is off until power good and held in default while reset is low.
  always_ff @(posedge clk) hub_on <= rails_good && hard_reset_n;
  // CPU pins follow the bench, which changes them at falling edges and holds each value long.
  assign {rsel, code} = vreq;
  assign thermal_n = !trip;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench of the sideband control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) chk(16'(a), 16'(e))
`define WAITC(c) begin k = 0; while (!(c) && k < 300) begin @(negedge clk); k++; end \
  if (k >= 300) begin error_cnt++; print_verdict(); end end
module testbench;
  logic clk, nrst, wake, rdclr, irq, sreq, regd, flag, vvalid, hreq, hrst_n, rok, osc, pgood;
  logic sx, sen, stby, swon, trip_n, trip_o, trip, xin, xout, sclk, hub_on;
  logic [1:0] vsel, rsel;
  logic [6:0] vcode, code;
  logic [8:0] vreq;
  int error_cnt, n_compared, k;
  localparam int OSC = 20;
  psc_sideband #(.DEB_CYC(8), .OSC_CYC(OSC)) i_dut (.CORE_CLK_I(clk), .NRST_I(nrst),
    .WAKE_EVENT_I(wake), .HUB_READ_CLEAR_I(rdclr), .HOST_WAKE_INTERRUPT_O(irq),
    .SERIAL_VREQ_I(sreq), .RAIL_REGULATED_I(regd), .REGULATION_DONE_FLAG_O(flag),
    .VREQ_VALID_O(vvalid), .VREQ_RAIL_SELECT_O(vsel), .VREQ_VOLTAGE_CODE_O(vcode),
    .HUB_RESET_REQ_I(hreq), .HUB_HARD_RESET_N_O(hrst_n), .HUB_RAILS_OK_I(rok),
    .OSCILLATOR_SUPPLY_I(osc), .RAILS_GOOD_O(pgood), .STANDBY_EXIT_REQUEST_I(sx),
    .STANDBY_ENTER_I(sen), .ALWAYS_ON_STANDBY_O(stby), .REGULATOR_SWITCH_ON_O(swon),
    .THERMAL_TRIP_N_I(trip_n), .THERMAL_TRIP_O(trip_o), .RAIL_SELECT_I(rsel),
    .VOLTAGE_CODE_I(code), .CRYSTAL_IN_I(xin), .CRYSTAL_OUT_O(xout), .SLOW_CLOCK_OUT_O(sclk));
  psc_hub_model i_hub (.clk(clk), .rails_good(pgood), .hard_reset_n(hrst_n), .trip(trip),
    .vreq(vreq), .hub_on(hub_on), .thermal_n(trip_n), .rsel(rsel), .code(code));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [15:0] a, input logic [15:0] e);
    n_compared++;
    if (a !== e)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task print_verdict;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // The value standing at the pins after reset is itself a stable request.
  task t_reset_request;
    `WAITC(vvalid)
    `CHK(k >= 7, 1);
    `CHK({vsel, vcode}, 9'h000);
    @(negedge clk);
    `CHK(flag, 1);
    pulse(regd);
    @(negedge clk);
    `CHK(flag, 0);
  endtask
  task t_wake;
    pulse(wake);
    repeat (3) @(negedge clk);
    `CHK(irq, 1);
    pulse(rdclr);
    @(negedge clk);
    `CHK(irq, 0);
  endtask
  task t_serial;
    pulse(sreq);
    `CHK(flag, 1);
    pulse(regd);
    @(negedge clk);
    `CHK(flag, 0);
  endtask
  task t_vcode(input logic [8:0] v);
    vreq = v;
    `WAITC(vvalid)
    `CHK(k >= 12, 1);
    `CHK({vsel, vcode}, v);
    @(negedge clk);
    `CHK(flag, 1);
    repeat (4) @(negedge clk);
    pulse(regd);
    @(negedge clk);
    `CHK(flag, 0);
  endtask
  task t_power;
    osc = 1'b1;
    rok = 1'b1;
    `WAITC(pgood)
    `CHK(k >= OSC, 1);
    `WAITC(hrst_n)
    `CHK(k < 3, 1);
    repeat (2) @(negedge clk);
    `CHK(hub_on, 1);
    hreq = 1'b1;
    `WAITC(!hrst_n)
    `CHK(k < 3, 1);
    hreq = 1'b0;
    rok = 1'b0;
    `WAITC(!pgood)
    `CHK(k < 8, 1);
    rok = 1'b1;
  endtask
  task t_standby;
    sx = 1'b1;
    `WAITC(swon)
    `CHK(stby, 0);
    @(negedge clk);
    `CHK(swon, 0);
    sx = 1'b0;
    pulse(sen);
    @(negedge clk);
    `CHK(stby, 1);
  endtask
  task t_misc;
    trip = 1'b1;
    `WAITC(trip_o)
    `CHK(k < 8, 1);
    trip = 1'b0;
    repeat (2) begin
      xin = ~xin;
      #1 `CHK(xout, !xin);
      `WAITC(sclk === xin)
      `CHK(k < 8, 1);
    end
  endtask
  initial
  begin
    {nrst, wake, rdclr, sreq, regd, hreq, rok, osc, sx, sen, trip, xin} = '0;
    vreq = 9'h000;
    error_cnt = 0;
    n_compared = 0;
    repeat (16) @(negedge clk);
    `CHK({irq, flag, pgood, hrst_n, stby}, 5'h01);
    nrst = 1'b1;
    @(negedge clk);
    t_reset_request();
    t_wake();
    t_serial();
    t_vcode(9'h155);
    t_vcode(9'h0AA);
    t_power();
    t_standby();
    t_misc();
    print_verdict();
  end
endmodule
`default_nettype wire
